/* File: rtl/trap_ctl_pkg.sv */
// Constants and carrier types for the trap and nesting control block.
// Assumes a 32-bit APB master on pclk; both registers use the low 16 bits.
package trap_ctl_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] off_trap_ctl   = 12'h000;
  localparam logic [11:0] off_global_ctl = 12'h004;

  // ************************************************************
  // Trap and nesting control fields
  // ************************************************************
  localparam int bit_nesting_off     = 15;
  localparam int bit_acc_a_ovf_cause = 14;
  localparam int bit_acc_b_ovf_cause = 13;
  localparam int bit_acc_a_cat_cause = 12;
  localparam int bit_acc_b_cat_cause = 11;
  localparam int bit_acc_a_ovf_en    = 10;
  localparam int bit_acc_b_ovf_en    = 9;
  localparam int bit_cat_en          = 8;
  localparam int bit_bad_shift       = 7;
  localparam int bit_zero_divisor    = 6;
  localparam int bit_dma_trap        = 5;
  localparam int bit_arith_trap      = 4;
  localparam int bit_bad_address     = 3;
  localparam int bit_stack_trap      = 2;
  localparam int bit_clock_loss      = 1;

  // ************************************************************
  // Global enable and edge control fields
  // ************************************************************
  localparam int bit_global_irq_on   = 15;
  localparam int bit_timed_block     = 14;
  localparam int bit_software_trap   = 13;
  localparam int bit_polarity_lsb    = 0;
  localparam int ext_irq_count       = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] rst_trap_ctl   = 16'h0000;
  localparam logic [15:0] rst_global_ctl = 16'h8000;

  // Trap sources, one-cycle pulses from the core
  typedef struct packed {
    logic acc_a_overflow;
    logic acc_b_overflow;
    logic acc_a_catastrophic;
    logic acc_b_catastrophic;
    logic bad_shift;
    logic zero_divisor;
    logic dma_fault;
    logic bad_address;
    logic stack_fault;
    logic clock_loss;
  } trap_events_s;

  // Control levels toward the core
  typedef struct packed {
    logic                     nesting_allowed;
    logic                     irqs_allowed;
    logic                     ipl_writable;
    logic                     software_trap;
    logic [ext_irq_count-1:0] ext_polarity;
  } core_ctl_s;

endpackage : trap_ctl_pkg

/* File: rtl/interrupt_trap_control_regs.sv */
// Trap and nesting control registers with APB access and edge detection.
// Assumes trap pulses come from logic on pclk; external irq pins are async.
//
// Operation
// - Nesting-off bit 15 set stops interrupt nesting; clear allows it.
// - Ordinary overflow trap of A or B sets cause bit 14 or 13.
// - Catastrophic overflow trap of A or B sets bit 12 or 11.
// - Bits 10 and 9 enable ordinary overflow traps for A and B.
// - Bit 8 enables catastrophic overflow traps for both accumulators.
// - Invalid accumulator shift math trap sets bit 7.
// - Divide by zero math trap sets bit 6.
// - Any DMA controller trap sets bit 5.
// - Any math error trap sets bit 4.
// - Address error trap sets bit 3.
// - Stack error trap sets bit 2.
// - Oscillator failure trap sets bit 1.
// - Unused bit 0 and bits 12 to 3 read as zero.
// - Global enable bit 15 resets to one; clear blocks irqs, not traps.
// - Bit 14 reads one while a timed irq block is active.
// - Bit 13 shows whether the software trap is enabled.
// - Polarity bits 2..0: one falling edge, zero rising edge request.
// - While nesting is off, cpu priority low bits are read-only.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module interrupt_trap_control_regs (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire trap_ctl_pkg::trap_events_s    trap_events,
  input  wire logic                          timed_block_active,
  input  wire logic [2:0]                    ext_irq_pin,
  output logic      [2:0]                    ext_irq_req,
  output logic                               math_trap_req,
  output trap_ctl_pkg::core_ctl_s            core_ctl
);

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic [15:0] trap_ctl;
  logic [15:0] global_ctl;
  logic [15:0] next_trap_ctl;
  logic [15:0] next_global_ctl;
  logic        next_pslverr;

  wire access_phase = psel & penable;
  wire hit_trap     = paddr == trap_ctl_pkg::off_trap_ctl;
  wire hit_global   = paddr == trap_ctl_pkg::off_global_ctl;
  wire hit_any      = hit_trap | hit_global;
  wire wr_trap      = access_phase & pwrite & hit_trap;
  wire wr_global    = access_phase & pwrite & hit_global;

  // Byte lanes: only the two low lanes carry register bits
  wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Zero-wait slave; every access completes in its first access cycle
  assign pready = 1'b1;

  // ************************************************************
  // Trap detection
  // ************************************************************
  wire ovf_en_a = trap_ctl[trap_ctl_pkg::bit_acc_a_ovf_en];
  wire ovf_en_b = trap_ctl[trap_ctl_pkg::bit_acc_b_ovf_en];
  wire cat_en   = trap_ctl[trap_ctl_pkg::bit_cat_en];

  // Overflow only traps when its enable is set
  wire ovf_trap_a = trap_events.acc_a_overflow & ovf_en_a;
  wire ovf_trap_b = trap_events.acc_b_overflow & ovf_en_b;
  wire cat_trap_a = trap_events.acc_a_catastrophic & cat_en;
  wire cat_trap_b = trap_events.acc_b_catastrophic & cat_en;

  // Accumulator traps are math traps too
  wire any_math = ovf_trap_a | ovf_trap_b | cat_trap_a | cat_trap_b
                | trap_events.bad_shift | trap_events.zero_divisor;

  // Hardware set vector, one bit per flag
  logic [15:0] set_vec;

  always_comb begin
    set_vec = 16'h0000;
    set_vec[trap_ctl_pkg::bit_acc_a_ovf_cause] = ovf_trap_a;
    set_vec[trap_ctl_pkg::bit_acc_b_ovf_cause] = ovf_trap_b;
    set_vec[trap_ctl_pkg::bit_acc_a_cat_cause] = cat_trap_a;
    set_vec[trap_ctl_pkg::bit_acc_b_cat_cause] = cat_trap_b;
    set_vec[trap_ctl_pkg::bit_bad_shift]       = trap_events.bad_shift;
    set_vec[trap_ctl_pkg::bit_zero_divisor]    = trap_events.zero_divisor;
    set_vec[trap_ctl_pkg::bit_dma_trap]        = trap_events.dma_fault;
    set_vec[trap_ctl_pkg::bit_arith_trap]      = any_math;
    set_vec[trap_ctl_pkg::bit_bad_address]     = trap_events.bad_address;
    set_vec[trap_ctl_pkg::bit_stack_trap]      = trap_events.stack_fault;
    set_vec[trap_ctl_pkg::bit_clock_loss]      = trap_events.clock_loss;
  end

  // ************************************************************
  // Trap and nesting control next value
  // ************************************************************
  // Bit 0 never stored, so it reads as zero
  localparam logic [15:0] trap_impl = 16'hfffe;

  wire [15:0] trap_written = (trap_ctl & ~lane_mask) | (pwdata[15:0] & lane_mask);
  wire [15:0] trap_base    = wr_trap ? trap_written : trap_ctl;

  // Set wins over a software clear in the same cycle
  assign next_trap_ctl = (trap_base | set_vec) & trap_impl;

  // ************************************************************
  // Global enable and edge control next value
  // ************************************************************
  // Only enable, software trap and polarity bits are stored
  localparam logic [15:0] global_impl = 16'ha007;

  wire [15:0] global_written = (global_ctl & ~lane_mask) | (pwdata[15:0] & lane_mask);

  assign next_global_ctl = (wr_global ? global_written : global_ctl) & global_impl;

  // ************************************************************
  // Register storage
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_ctl   <= trap_ctl_pkg::rst_trap_ctl;
      global_ctl <= trap_ctl_pkg::rst_global_ctl;
    end else begin
      trap_ctl   <= next_trap_ctl;
      global_ctl <= next_global_ctl;
    end
  end

  // ************************************************************
  // Read view
  // ************************************************************
  logic [15:0] global_view;

  always_comb begin
    global_view = global_ctl;
    // Live status, not stored, so software cannot fake it
    global_view[trap_ctl_pkg::bit_timed_block] = timed_block_active;
  end

  wire [15:0] read_sel = hit_trap   ? trap_ctl    :
                         hit_global ? global_view : 16'h0000;

  // Unmapped address: error response, read data zero
  assign next_pslverr = access_phase & ~hit_any;

  // Data output comes from flops; the handshake is combinational
  logic [31:0] read_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_q <= 32'h0000_0000;
    end else begin
      read_q <= {16'h0000, read_sel};
    end
  end

  // Address is stable from setup, so the flop holds it by access phase
  assign prdata  = (access_phase & ~pwrite) ? read_q : 32'h0000_0000;
  assign pslverr = next_pslverr;

  // ************************************************************
  // External interrupt edge detection
  // ************************************************************
  // Two flops per pin before any logic; third stage holds last level
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_last <= 3'h0;
    end else begin
      pin_meta <= ext_irq_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  logic [2:0] next_ext_irq_req;

  genvar g;
  generate
    for (g = 0; g < trap_ctl_pkg::ext_irq_count; g++) begin : g_edge
      wire falling  = global_ctl[trap_ctl_pkg::bit_polarity_lsb + g];
      wire rise_seen = pin_sync[g] & ~pin_last[g];
      wire fall_seen = ~pin_sync[g] & pin_last[g];
      // One selects falling edge, zero rising edge
      assign next_ext_irq_req[g] = falling ? fall_seen : rise_seen;
    end
  endgenerate

  // Requests are not gated by the global enable here; the core applies it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_req <= 3'h0;
    end else begin
      ext_irq_req <= next_ext_irq_req;
    end
  end

  // ************************************************************
  // Math trap request toward the core
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      math_trap_req <= 1'b0;
    end else begin
      math_trap_req <= any_math;
    end
  end

  // ************************************************************
  // Control levels toward the core
  // ************************************************************
  wire nest_off = trap_ctl[trap_ctl_pkg::bit_nesting_off];

  always_comb begin
    core_ctl.nesting_allowed = ~nest_off;
    core_ctl.ipl_writable    = ~nest_off;
    // Traps are never masked by this bit, only interrupts
    core_ctl.irqs_allowed    = global_ctl[trap_ctl_pkg::bit_global_irq_on];
    core_ctl.software_trap   = global_ctl[trap_ctl_pkg::bit_software_trap];
    core_ctl.ext_polarity    = global_ctl[trap_ctl_pkg::bit_polarity_lsb +: 3];
  end

endmodule : interrupt_trap_control_regs

/* File: tb/trap_src_model.sv */
// Behavioural core and trap source side of the trap control block.
// Assumes bench requests arrive just after pclk edges.
`timescale 1ns/1ps

module trap_src_model (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       fire,
  input  wire trap_ctl_pkg::trap_events_s ev,
  input  wire logic                       blk,
  input  wire logic [2:0]                 pins,
  output trap_ctl_pkg::trap_events_s      trap_events,
  output logic                            timed_block_active,
  output logic [2:0]                      ext_irq_pin
);
  // ************************************************************
  // Core outputs
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_events <= '0;
      timed_block_active <= 1'b0;
      ext_irq_pin <= 3'h0;
    end else begin
      // Trap causes last as long as fire is held high
      trap_events <= fire ? ev : '0;
      timed_block_active <= blk;
      ext_irq_pin <= pins;
    end
  end
endmodule : trap_src_model

/* File: tb/interrupt_trap_control_regs_sva.sv */
// Port assertions for the trap control block.
// Assumes one pclk domain and async active-low presetn.
`timescale 1ns/1ps

module trap_ctl_checker (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [11:0]                paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire trap_ctl_pkg::trap_events_s trap_events,
  input wire logic                       timed_block_active,
  input wire logic [2:0]                 ext_irq_pin,
  input wire logic [2:0]                 ext_irq_req,
  input wire logic                       math_trap_req,
  input wire trap_ctl_pkg::core_ctl_s    core_ctl
);
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_acc  = psel && penable && !pwrite;
  wire wr_acc  = psel && penable && pwrite && pstrb[1:0] == 2'b11;
  wire wr_trap = wr_acc && paddr == 12'h000;
  wire wr_glb  = wr_acc && paddr == 12'h004;
  nest_ctl_a: assert property (wr_trap |=> core_ctl.nesting_allowed == !$past(pwdata[15]))
    else $error("nesting control not taken");
  ipl_lock_a: assert property (wr_trap |=> core_ctl.ipl_writable == !$past(pwdata[15]))
    else $error("priority lock disagrees with nesting");
  glb_en_a: assert property (wr_glb |=> core_ctl.irqs_allowed == $past(pwdata[15]))
    else $error("global enable not taken");
  sw_trap_a: assert property (wr_glb |=> core_ctl.software_trap == $past(pwdata[13]))
    else $error("software trap not taken");
  pol_sel_a: assert property (wr_glb |=> core_ctl.ext_polarity == $past(pwdata[2:0]))
    else $error("polarity not taken");
  math_req_a: assert property (trap_events.bad_shift || trap_events.zero_divisor |=> math_trap_req)
    else $error("math trap request missing");
  unused_zero_a: assert property (rd_acc |-> prdata[31:16] == 16'h0000 && (paddr != 12'h000 || !prdata[0])
    && (paddr != 12'h004 || prdata[12:3] == 10'h000)) else $error("unused bits not zero");
  timed_blk_a: assert property (rd_acc && paddr == 12'h004 |-> prdata[14] == $past(timed_block_active))
    else $error("timed block status wrong");
  ext_edge_a: assert property ($rose(ext_irq_pin[0]) && !core_ctl.ext_polarity[0] |-> ##[2:4] ext_irq_req[0])
    else $error("rising edge request missing");
endmodule : trap_ctl_checker

bind interrupt_trap_control_regs trap_ctl_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .trap_events(trap_events), .timed_block_active(timed_block_active), .ext_irq_pin(ext_irq_pin),
  .ext_irq_req(ext_irq_req), .math_trap_req(math_trap_req), .core_ctl(core_ctl));

/* File: tb/interrupt_trap_control_regs_bench.sv */
// Self-checking bench for the trap control block.
// Assumes zero-wait APB slave and trap_src_model as the core side.
`timescale 1ns/1ps

module interrupt_trap_control_regs_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic fire = 1'b0, blk = 1'b0, pready, pslverr, timed_block_active, math_trap_req;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, seed = 32'h00013a85;
  logic [2:0] pins = 3'h0, ext_irq_pin, ext_irq_req;
  trap_ctl_pkg::trap_events_s ev = '0, trap_events;
  trap_ctl_pkg::core_ctl_s core_ctl;
  logic [32:0] exp_q[$];
  logic [15:0] tbl[10] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090, 16'h0050, 16'h0020,
                           16'h0008, 16'h0004, 16'h0002};
  int error_cnt = 0, n_tests = 0, irq_cnt = 0;

  always #5 pclk = ~pclk;
  interrupt_trap_control_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trap_events(trap_events), .timed_block_active(timed_block_active),
    .ext_irq_pin(ext_irq_pin), .ext_irq_req(ext_irq_req), .math_trap_req(math_trap_req), .core_ctl(core_ctl));
  trap_src_model i_src (.pclk(pclk), .presetn(presetn), .fire(fire), .ev(ev), .blk(blk), .pins(pins),
    .trap_events(trap_events), .timed_block_active(timed_block_active), .ext_irq_pin(ext_irq_pin));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] expv);
    n_tests++;
    if (seen !== expv) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) exp_q.push_back(e);
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps each strobe to one assignment per step
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 33'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h00000000, e);
  endtask : rd
  task automatic pulse(input logic [9:0] e);
    ev <= e;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  task automatic finish_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // Oldest noted read result against each completed read
  always @(posedge pclk) begin
    irq_cnt <= irq_cnt + $countones(ext_irq_req);
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
      check("read data", {pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int r = 0; r < 2; r++) begin
      rd(12'h000, 33'h0);
      rd(12'h004, 33'h000008000);
      wr(12'h000, 32'hffffffff);
      rd(12'h000, 33'h00000fffe);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
    end
    rd(12'h008, 33'h100000000);
    for (int i = 0; i < 10; i++) begin
      wr(12'h000, 32'h00000700);
      pulse(10'h200 >> i);
      rd(12'h000, {17'h0, tbl[i] | 16'h0700});
      wr(12'h000, 32'h00000000);
      pulse(10'h200 >> i);
      rd(12'h000, {17'h0, (i < 4) ? 16'h0000 : tbl[i]});
    end
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      blk <= seed[20];
      wr(12'h004, seed);
      rd(12'h004, {17'h0, (seed[15:0] & 16'ha007) | {1'b0, seed[20], 14'h0}});
    end
    blk <= 1'b0;
    wr(12'h004, 32'h00000000);
    repeat (2) begin
      pins <= 3'h7;
      repeat (8) @(posedge pclk);
      pins <= 3'h0;
      repeat (8) @(posedge pclk);
      wr(12'h004, 32'h00000007);
    end
    check("edge requests", 33'(irq_cnt), 33'd6);
    finish_test();
  end
endmodule : interrupt_trap_control_regs_bench
